/* File: design/cpu_requester.sv */
// CPU-side end: turns one-shot user requests into held bus accesses.
// Assumes the decoder acks one cycle after taking; suspend gated by erase gap.
`timescale 1ns/1ps
module cpu_requester (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Decoder side
    mem_bus_if.cpu           bus,
    // User side
    input  wire logic        user_go,
    input  wire logic        user_we,
    input  wire logic [19:0] user_addr,
    input  wire logic [7:0]  user_wdata,
    input  wire logic        user_suspend,
    input  wire logic        user_resume,
    input  wire logic        erase_gap_ok,
    output logic             user_done,
    output logic [7:0]       user_rdata,
    output logic             user_refused
);
    // ----------------------------------------------------------------
    // Access holding
    // ----------------------------------------------------------------
    logic        req_r, we_r, done_r, refused_r, susp_r, resume_r;
    logic [19:0] addr_r;
    logic [7:0]  wdata_r, rdata_r;
    wire         in_sfr   = user_addr <= memmap_pkg::SFR_HI;
    wire         is_fcreg = user_addr == memmap_pkg::FC4_ADDR ||
                            user_addr == memmap_pkg::FC1_ADDR ||
                            user_addr == memmap_pkg::FC0_ADDR;
    wire         blocked  = in_sfr && !is_fcreg;
    wire         launch   = user_go && !req_r && !blocked;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            req_r     <= 1'b0;
            we_r      <= 1'b0;
            addr_r    <= 20'h00000;
            wdata_r   <= 8'h00;
            rdata_r   <= 8'h00;
            done_r    <= 1'b0;
            refused_r <= 1'b0;
            susp_r    <= 1'b0;
            resume_r  <= 1'b0;
        end else begin
            done_r    <= req_r && bus.ack;
            refused_r <= user_go && !req_r && blocked;
            if (launch) begin
                req_r   <= 1'b1;
                we_r    <= user_we;
                addr_r  <= user_addr;
                wdata_r <= user_wdata;
            end else if (bus.ack) begin
                req_r   <= 1'b0;
                rdata_r <= bus.rdata;
            end
            susp_r   <= user_suspend && bus.busy && erase_gap_ok;
            resume_r <= user_resume && bus.suspended;
        end
    end

    assign bus.req        = req_r;
    assign bus.we         = we_r;
    assign bus.addr       = addr_r;
    assign bus.wdata      = wdata_r;
    assign bus.susp_req   = susp_r;
    assign bus.resume_req = resume_r;
    assign user_done      = done_r;
    assign user_rdata     = rdata_r;
    assign user_refused   = refused_r;

endmodule : cpu_requester

/* File: design/mem_bus_if.sv */
// Interface joining the CPU-side requester and the memory decoder.
// Assumes both ends share sys_clk; the bench ties the clock in.
`timescale 1ns/1ps
interface mem_bus_if (
    input wire logic sys_clk
);
    logic        req;
    logic        we;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        ack;
    logic [7:0]  rdata;
    logic [2:0]  region;
    logic        susp_req;
    logic        resume_req;
    logic        suspended;
    logic        busy;

    modport cpu (
        input  sys_clk, ack, rdata, region, suspended, busy,
        output req, we, addr, wdata, susp_req, resume_req
    );
    modport mem (
        input  sys_clk, req, we, addr, wdata, susp_req, resume_req,
        output ack, rdata, region, suspended, busy
    );
endinterface : mem_bus_if

/* File: design/mem_decoder.sv */
// Memory-map decoder with RAM, flash control registers and suspend sequencer.
// Assumes the requester holds a request until ack; ROM and data flash contents
// are modelled as reading the unmapped value, except the option byte.
`timescale 1ns/1ps
module mem_decoder (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // CPU side
    mem_bus_if.mem                      bus,
    // Configuration
    input  wire memmap_pkg::rom_size_t  rom_size,
    input  wire memmap_pkg::ram_size_t  ram_size,
    input  wire logic [7:0]             opt_value,
    // Flash operation start and done
    input  wire logic                   flash_start,
    input  wire logic                   flash_is_erase,
    input  wire logic                   flash_done,
    // Status
    output logic                        erase_gap_ok
);
    localparam int RAM_DEPTH = 1536;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic [7:0]            ram_mem [RAM_DEPTH];
    logic [7:0]            fc4_r, fc1_r, fc0_r;
    logic                  ack_r;
    logic [7:0]            rdata_r;
    logic [2:0]            region_r;
    memmap_pkg::region_t   reg_cls;
    wire                   take      = bus.req && !ack_r;
    wire                   hit_fc4   = bus.addr == memmap_pkg::FC4_ADDR;
    wire                   hit_fc1   = bus.addr == memmap_pkg::FC1_ADDR;
    wire                   hit_fc0   = bus.addr == memmap_pkg::FC0_ADDR;
    wire                   hit_opt   = bus.addr == memmap_pkg::OPT_ADDR;
    wire                   is_ram;
    wire [10:0]            ram_idx   = 11'(bus.addr - memmap_pkg::RAM_LO);
    logic [7:0]            rd_sel;

    assign reg_cls = memmap_pkg::classify(bus.addr, rom_size,
                                          ram_size);
    assign is_ram  = reg_cls == memmap_pkg::REG_RAM;

    always_comb begin
        if (hit_fc4)
            rd_sel = fc4_r;
        else if (hit_fc1)
            rd_sel = fc1_r;
        else if (hit_fc0)
            rd_sel = fc0_r;
        else if (hit_opt)
            rd_sel = opt_value;
        else if (is_ram)
            rd_sel = ram_mem[ram_idx];
        else
            rd_sel = memmap_pkg::UNMAPPED_VAL;
    end

    // ----------------------------------------------------------------
    // Access handshake and storage
    // ----------------------------------------------------------------
    wire                   wr_take   = take && bus.we;
    wire                   wr_fc4    = wr_take && hit_fc4;
    wire                   wr_fc1    = wr_take && hit_fc1;
    wire                   wr_fc0    = wr_take && hit_fc0;
    wire                   wr_ram    = wr_take && is_ram;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_r    <= 1'b0;
            rdata_r  <= 8'h00;
            region_r <= 3'h0;
        end else begin
            ack_r <= take;
            if (take) begin
                rdata_r  <= bus.we ? 8'h00 : rd_sel;
                region_r <= 3'(reg_cls);
            end
        end
    end

    // ----------------------------------------------------------------
    // Flash control registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fc4_r <= memmap_pkg::FC4_RST;
            fc1_r <= memmap_pkg::FC1_RST;
            fc0_r <= memmap_pkg::FC0_RST;
        end else begin
            if (wr_fc4)
                fc4_r <= bus.wdata;
            if (wr_fc1)
                fc1_r <= bus.wdata;
            if (wr_fc0)
                fc0_r <= bus.wdata;
        end
    end

    // Data and stack storage; writes outside RAM are dropped
    always_ff @(posedge sys_clk) begin
        if (wr_ram)
            ram_mem[ram_idx] <= bus.wdata;
    end

    assign bus.ack    = ack_r;
    assign bus.rdata  = rdata_r;
    assign bus.region = region_r;

    // ----------------------------------------------------------------
    // Flash suspend and restart sequencer
    // ----------------------------------------------------------------
    memmap_pkg::flash_state_t   st_r, st_nxt;
    logic [memmap_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [memmap_pkg::CNT_W-1:0] gap_r;
    logic                       erase_r;
    logic                       gap_ok_r;
    logic                       susp_pend_r;
    logic                       resume_pend_r;
    wire                        susp_due   = susp_pend_r &&
                                cnt_r == memmap_pkg::CNT_W'(memmap_pkg::SUSP_CYC - 1);
    wire                        resume_due = resume_pend_r &&
                                cnt_r == memmap_pkg::CNT_W'(memmap_pkg::RESTART_CYC - 1);
    wire                        entering   = st_nxt == memmap_pkg::FL_BUSY &&
                                             st_r != memmap_pkg::FL_BUSY;
    wire                        erase_run  = (st_r == memmap_pkg::FL_IDLE) ? flash_is_erase
                                                                            : erase_r;
    logic                       susp_flag_r;
    logic                       busy_flag_r;

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = (susp_pend_r || resume_pend_r) ? cnt_r + 1'b1 : '0;
        case (st_r)
            memmap_pkg::FL_IDLE: begin
                if (flash_start)
                    st_nxt = memmap_pkg::FL_BUSY;
            end
            memmap_pkg::FL_BUSY: begin
                if (flash_done)
                    st_nxt = memmap_pkg::FL_IDLE;
                else if (susp_due)
                    st_nxt = memmap_pkg::FL_SUSPEND;
            end
            memmap_pkg::FL_SUSPEND: begin
                if (resume_due)
                    st_nxt = memmap_pkg::FL_BUSY;
            end
            default: st_nxt = memmap_pkg::FL_IDLE;
        endcase
        if (st_nxt != st_r)
            cnt_nxt = '0;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r          <= memmap_pkg::FL_IDLE;
            cnt_r         <= '0;
            susp_pend_r   <= 1'b0;
            resume_pend_r <= 1'b0;
            erase_r       <= 1'b0;
            susp_flag_r   <= 1'b0;
            busy_flag_r   <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            if (st_r == memmap_pkg::FL_BUSY && bus.susp_req)
                susp_pend_r <= 1'b1;
            else if (st_nxt != memmap_pkg::FL_BUSY)
                susp_pend_r <= 1'b0;
            if (st_r == memmap_pkg::FL_SUSPEND && bus.resume_req)
                resume_pend_r <= 1'b1;
            else if (st_nxt != memmap_pkg::FL_SUSPEND)
                resume_pend_r <= 1'b0;
            if (st_r == memmap_pkg::FL_IDLE && flash_start)
                erase_r <= flash_is_erase;
            susp_flag_r <= st_nxt == memmap_pkg::FL_SUSPEND;
            busy_flag_r <= st_nxt == memmap_pkg::FL_BUSY;
        end
    end

    // ----------------------------------------------------------------
    // Erase gap timer
    // ----------------------------------------------------------------
    // Erase start or restart opens the no-suspend gap; a program start closes it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gap_r    <= '0;
            gap_ok_r <= 1'b1;
        end else if (entering && erase_run) begin
            gap_r    <= memmap_pkg::CNT_W'(memmap_pkg::ERASE_GAP_CYC - 1);
            gap_ok_r <= 1'b0;
        end else if (entering) begin
            gap_r    <= '0;
            gap_ok_r <= 1'b1;
        end else if (gap_r != '0) begin
            gap_r <= gap_r - 1'b1;
        end else begin
            gap_ok_r <= 1'b1;
        end
    end

    assign bus.suspended = susp_flag_r;
    assign bus.busy      = busy_flag_r;
    assign erase_gap_ok  = gap_ok_r;

endmodule : mem_decoder

/* File: design/memmap_pkg.sv */
// Constants, types and helpers shared by the memory decoder and the CPU-side requester.
// Assumes a single 25 MHz clock and an active-high asynchronous reset.
//
// Summary of operation
// - Flat 1 Mbyte space, every address classified.
// - Program ROM ends 0FFFFh, base follows size.
// - RAM starts 00400h, length follows size.
// - Vector table 0FFDCh to 0FFFFh inside ROM.
// - Data flash 02400h-02BFFh, blocks A and B.
// - Register area 00000h to 002FFh.
// - Software avoids reserved and unassigned locations.
// - RAM holds data and the stack.
// - Option byte at FFFFh is read only.
// - Flash control registers at 01B3h/01B5h/01B7h.
// - No flash address programmed twice per erase.
// - Suspend within 97 us plus 6 cycles.
// - Wait 650 us after erase start to suspend.
// - Restart within 3 us plus 4 cycles.
// - Erase error: clear status, retry erase.
package memmap_pkg;

    localparam int          ADDR_W        = 20;
    localparam int          CLK_MHZ       = 25;

    // ----------------------------------------------------------------
    // Region bounds
    // ----------------------------------------------------------------
    localparam logic [19:0] SFR_LO        = 20'h00000;
    localparam logic [19:0] SFR_HI        = 20'h002FF;
    localparam logic [19:0] RAM_LO        = 20'h00400;
    localparam logic [19:0] RAM_HI_512    = 20'h005FF;
    localparam logic [19:0] RAM_HI_1K     = 20'h007FF;
    localparam logic [19:0] RAM_HI_1K5    = 20'h009FF;
    localparam logic [19:0] DFL_LO        = 20'h02400;
    localparam logic [19:0] DFL_B_LO      = 20'h02800;
    localparam logic [19:0] DFL_HI        = 20'h02BFF;
    localparam logic [19:0] ROM_HI        = 20'h0FFFF;
    localparam logic [19:0] ROM_LO_8K     = 20'h0E000;
    localparam logic [19:0] ROM_LO_16K    = 20'h0C000;
    localparam logic [19:0] ROM_LO_24K    = 20'h0A000;
    localparam logic [19:0] ROM_LO_32K    = 20'h08000;
    localparam logic [19:0] VEC_LO        = 20'h0FFDC;
    localparam logic [19:0] OPT_ADDR      = 20'h0FFFF;

    // ----------------------------------------------------------------
    // Flash control registers
    // ----------------------------------------------------------------
    localparam logic [19:0] FC4_ADDR      = 20'h001B3;
    localparam logic [19:0] FC1_ADDR      = 20'h001B5;
    localparam logic [19:0] FC0_ADDR      = 20'h001B7;
    localparam logic [7:0]  FC4_RST       = 8'h40;
    localparam logic [7:0]  FC1_RST       = 8'h80;
    localparam logic [7:0]  FC0_RST       = 8'h01;
    localparam logic [7:0]  OPT_DEFAULT   = 8'hFF;
    localparam logic [7:0]  UNMAPPED_VAL  = 8'hFF;

    // ----------------------------------------------------------------
    // Suspend timing
    // ----------------------------------------------------------------
    localparam int          SUSP_US       = 97;
    localparam int          SUSP_EXTRA    = 6;
    localparam int          RESTART_US    = 3;
    localparam int          RESTART_EXTRA = 4;
    localparam int          ERASE_GAP_US  = 650;
    localparam int          SUSP_CYC      = SUSP_US * CLK_MHZ + SUSP_EXTRA;
    localparam int          RESTART_CYC   = RESTART_US * CLK_MHZ + RESTART_EXTRA;
    localparam int          ERASE_GAP_CYC = ERASE_GAP_US * CLK_MHZ;
    localparam int          CNT_W         = 15;

    typedef enum logic [2:0] {
        REG_NONE  = 3'b000,
        REG_SFR   = 3'b001,
        REG_RAM   = 3'b010,
        REG_DFL_A = 3'b011,
        REG_DFL_B = 3'b100,
        REG_ROM   = 3'b101,
        REG_VEC   = 3'b110
    } region_t;

    typedef enum logic [1:0] {
        ROM_8K  = 2'b00,
        ROM_16K = 2'b01,
        ROM_24K = 2'b10,
        ROM_32K = 2'b11
    } rom_size_t;

    typedef enum logic [1:0] {
        RAM_512 = 2'b00,
        RAM_1K  = 2'b01,
        RAM_1K5 = 2'b10
    } ram_size_t;

    typedef enum logic [1:0] {
        FL_IDLE    = 2'b00,
        FL_BUSY    = 2'b01,
        FL_SUSPEND = 2'b10
    } flash_state_t;

    function automatic logic [19:0] rom_base(input rom_size_t s);
        case (s)
            ROM_8K:  rom_base = ROM_LO_8K;
            ROM_16K: rom_base = ROM_LO_16K;
            ROM_24K: rom_base = ROM_LO_24K;
            default: rom_base = ROM_LO_32K;
        endcase
    endfunction : rom_base

    function automatic logic [19:0] ram_top(input ram_size_t s);
        case (s)
            RAM_512: ram_top = RAM_HI_512;
            RAM_1K:  ram_top = RAM_HI_1K;
            default: ram_top = RAM_HI_1K5;
        endcase
    endfunction : ram_top

    function automatic region_t classify(input logic [19:0] a, input rom_size_t rs,
                                         input ram_size_t ms);
        if (a <= SFR_HI)                                  classify = REG_SFR;
        else if (a >= RAM_LO && a <= ram_top(ms))         classify = REG_RAM;
        else if (a >= DFL_LO && a < DFL_B_LO)             classify = REG_DFL_A;
        else if (a >= DFL_B_LO && a <= DFL_HI)            classify = REG_DFL_B;
        else if (a >= VEC_LO && a <= ROM_HI)              classify = REG_VEC;
        else if (a >= rom_base(rs) && a <= ROM_HI)        classify = REG_ROM;
        else                                              classify = REG_NONE;
    endfunction : classify

endpackage : memmap_pkg

/* File: tb/memory_map_decoder_monitor.sv */
// Checker for the decoder bus: handshake, region decode, suspend timing.
// Assumes it sits beside mem_bus_if and sees its signals as plain inputs.
`timescale 1ns/1ps
module memory_map_decoder_monitor (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Bus signals
    input wire logic        req,
    input wire logic        we,
    input wire logic [19:0] addr,
    input wire logic        ack,
    input wire logic [7:0]  rdata,
    input wire logic [2:0]  region,
    input wire logic        susp_req,
    input wire logic        resume_req,
    input wire logic        suspended,
    input wire logic        busy
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    logic        pend_r;
    logic [15:0] cnt_r;
    wire         take = susp_req && busy && !suspended && !pend_r;

    // Cycles since a suspend request was taken
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend_r <= 1'b0;
            cnt_r  <= 16'h0000;
        end else begin
            pend_r <= take || (pend_r && busy && !suspended);
            cnt_r  <= take ? 16'h0000 : cnt_r + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    ack_follows_take_a: assert property (req && !ack |=> ack)
        else $error("no ack one cycle after a taken request");
    ack_one_cycle_a: assert property (ack |=> !ack)
        else $error("ack held longer than one cycle");
    ack_needs_req_a: assert property (!req |=> !ack)
        else $error("ack without a request");
    sfr_region_a: assert property (ack && addr <= memmap_pkg::SFR_HI
        |-> region == memmap_pkg::REG_SFR) else $error("register area misdecoded");
    flash_region_a: assert property (ack && addr >= memmap_pkg::DFL_LO
        && addr <= memmap_pkg::DFL_HI |-> region == (addr[11] ? memmap_pkg::REG_DFL_B
        : memmap_pkg::REG_DFL_A)) else $error("data flash block misdecoded");
    vector_region_a: assert property (ack && addr >= memmap_pkg::VEC_LO
        && addr <= memmap_pkg::ROM_HI |-> region == memmap_pkg::REG_VEC)
        else $error("vector table misdecoded");
    high_none_a: assert property (ack && addr > memmap_pkg::ROM_HI
        |-> region == memmap_pkg::REG_NONE) else $error("upper space not reserved");
    reserved_read_a: assert property (ack && !we && region == memmap_pkg::REG_NONE
        |-> rdata == memmap_pkg::UNMAPPED_VAL) else $error("reserved read value wrong");
    suspend_time_a: assert property ($rose(suspended) |-> pend_r
        && cnt_r >= 16'(memmap_pkg::SUSP_CYC - 3) && cnt_r <= 16'(memmap_pkg::SUSP_CYC + 1))
        else $error("suspend entered at the wrong time");
    restart_time_a: assert property (resume_req && suspended
        |-> ##[77:81] $rose(busy)) else $error("restart not within its bound");

    cover property (ack && we);
    cover property (ack && region == memmap_pkg::REG_NONE);
    cover property ($rose(suspended));
endmodule : memory_map_decoder_monitor

/* File: tb/test_memory_map_decoder.sv */
// Self-checking bench joining the requester and the decoder.
// Assumes the design files compile first; user side driven at falling edges.
`timescale 1ns/1ps
module test_memory_map_decoder;
    logic                  sys_clk = 1'b0, rst = 1'b1, user_go = 1'b0, user_we = 1'b0;
    logic                  user_suspend = 1'b0, user_resume = 1'b0, flash_start = 1'b0;
    logic                  flash_is_erase = 1'b0, flash_done = 1'b0;
    logic                  erase_gap_ok, user_done, user_refused;
    logic [19:0]           user_addr = 20'h00000, a;
    logic [7:0]            user_wdata = 8'h00, opt_value = 8'h00, user_rdata, d;
    memmap_pkg::rom_size_t rom_size = memmap_pkg::ROM_8K;
    memmap_pkg::ram_size_t ram_size = memmap_pkg::RAM_512;
    int                    err_total = 0, check_count = 0, c;
    logic [12:0]           exp_q[$], e;
    logic [19:0]           tab[10] = '{20'h02400, 20'h027FF, 20'h02800, 20'h02BFF,
        20'h0FFDC, 20'h10000, 20'hFFFFF, 20'h003FF, 20'h00000, 20'h001B4};

    mem_bus_if i_mem_bus_if (.sys_clk(sys_clk));
    mem_decoder i_mem_decoder (.sys_clk(sys_clk), .rst(rst), .bus(i_mem_bus_if),
        .rom_size(rom_size), .ram_size(ram_size), .opt_value(opt_value),
        .flash_start(flash_start), .flash_is_erase(flash_is_erase),
        .flash_done(flash_done), .erase_gap_ok(erase_gap_ok));
    cpu_requester i_cpu_requester (.sys_clk(sys_clk), .rst(rst), .bus(i_mem_bus_if),
        .user_go(user_go), .user_we(user_we), .user_addr(user_addr),
        .user_wdata(user_wdata), .user_suspend(user_suspend), .user_resume(user_resume),
        .erase_gap_ok(erase_gap_ok), .user_done(user_done), .user_rdata(user_rdata),
        .user_refused(user_refused));
    memory_map_decoder_monitor i_monitor (.sys_clk(sys_clk), .rst(rst),
        .req(i_mem_bus_if.req), .we(i_mem_bus_if.we), .addr(i_mem_bus_if.addr),
        .ack(i_mem_bus_if.ack), .rdata(i_mem_bus_if.rdata), .region(i_mem_bus_if.region),
        .susp_req(i_mem_bus_if.susp_req), .resume_req(i_mem_bus_if.resume_req),
        .suspended(i_mem_bus_if.suspended), .busy(i_mem_bus_if.busy));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("Counts: %0d checks, %0d mismatches", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    function automatic logic [2:0] reg_of(input logic [19:0] x);
        if (x <= 20'h002FF) return 3'h1;
        if (x >= 20'h00400 && x <= 20'h005FF + 20'(ram_size) * 20'h00200) return 3'h2;
        if (x >= 20'h02400 && x <= 20'h02BFF) return x[11] ? 3'h4 : 3'h3;
        if (x >= 20'h0FFDC && x <= 20'h0FFFF) return 3'h6;
        if (x >= 20'h0E000 - 20'(rom_size) * 20'h02000 && x <= 20'h0FFFF) return 3'h5;
        return 3'h0;
    endfunction : reg_of

    task automatic access(input logic w, input logic [19:0] x, input logic [7:0] v,
                          input logic [7:0] rd);
        logic refd;
        refd = reg_of(x) == 3'h1 && x != 20'h001B3 && x != 20'h001B5 && x != 20'h001B7;
        @(negedge sys_clk);
        user_we = w;
        user_addr = x;
        user_wdata = v;
        user_go = 1'b1;
        exp_q.push_back({w, refd, reg_of(x), rd});
        @(negedge sys_clk);
        user_go = 1'b0;
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge sys_clk);
        check("pending", 20'(exp_q.size()), 20'h00000);
        exp_q.delete();
    endtask : access

    task automatic pulse_wait(input logic res, input int lo, input int hi);
        @(negedge sys_clk);
        if (res) user_resume = 1'b1;
        else user_suspend = 1'b1;
        @(negedge sys_clk);
        user_resume = 1'b0;
        user_suspend = 1'b0;
        c = 0;
        while (c < 3000 &&
               (res ? i_mem_bus_if.busy !== 1'b1 : i_mem_bus_if.suspended !== 1'b1)) begin
            @(negedge sys_clk);
            c++;
        end
        check(res ? "restart_time" : "suspend_time",
              20'(c >= lo && c <= hi), 20'h1);
    endtask : pulse_wait

    always @(negedge sys_clk) if (user_done === 1'b1 || user_refused === 1'b1) begin
        e = exp_q.pop_front();
        check("refused", 20'(user_refused), 20'(e[11]));
        if (!e[11]) check("region", 20'(i_mem_bus_if.region), 20'(e[10:8]));
        if (!e[11] && !e[12]) check("rdata", 20'(user_rdata), 20'(e[7:0]));
    end

    // ----------------------------------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------------------------------
    initial forever #20 sys_clk = ~sys_clk;

    initial begin
        #2400000;
        err_total++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h4561));
        repeat (20) @(negedge sys_clk);
        check("reset_idle", 20'({i_mem_bus_if.ack, i_mem_bus_if.busy,
              i_mem_bus_if.suspended, erase_gap_ok}), 20'h1);
        rst = 1'b0;
        access(0, 20'h001B3, 8'h00, 8'h40);
        access(0, 20'h001B5, 8'h00, 8'h80);
        access(0, 20'h001B7, 8'h00, 8'h01);
        opt_value = 8'($urandom);
        access(1, 20'h0FFFF, ~opt_value, 8'h00);
        access(0, 20'h0FFFF, 8'h00, opt_value);
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            access(1, 20'h001B3 + 20'(2 * i), d, 8'h00);
            access(0, 20'h001B3 + 20'(2 * i), 8'h00, d);
        end
        $display("test flash registers done");
        for (int i = 0; i < 12; i++) begin
            rom_size = memmap_pkg::rom_size_t'(i / 3);
            ram_size = memmap_pkg::ram_size_t'(i % 3);
            a = 20'h005FF + 20'(i % 3) * 20'h00200;
            d = 8'($urandom);
            access(1, a, d, 8'h00);
            access(0, a, 8'h00, d);
            access(1, a + 20'h1, d, 8'h00);
            access(0, a + 20'h1, 8'h00, 8'hFF);
            a = 20'h0E000 - 20'(i / 3) * 20'h02000;
            access(0, a, 8'h00, 8'hFF);
            access(0, a - 20'h1, 8'h00, 8'hFF);
        end
        foreach (tab[i]) access(0, tab[i], 8'h00, 8'hFF);
        repeat (16) begin
            a = 20'h00400 + 20'($urandom_range(0, 511));
            d = 8'($urandom);
            access(1, a, d, 8'h00);
            access(0, a, 8'h00, d);
        end
        $display("test region decode done");
        for (int k = 1; k >= 0; k--) begin
            @(negedge sys_clk);
            flash_is_erase = k[0];
            flash_start = 1'b1;
            @(negedge sys_clk);
            flash_start = 1'b0;
            @(negedge sys_clk);
            check("gap_after_start", 20'(erase_gap_ok), 20'(k == 0));
            if (k == 1) begin
                repeat (memmap_pkg::ERASE_GAP_CYC - 8) @(negedge sys_clk);
                check("gap_early", 20'(erase_gap_ok), 20'h0);
                repeat (12) @(negedge sys_clk);
                check("gap_late", 20'(erase_gap_ok), 20'h1);
            end
            pulse_wait(0, memmap_pkg::SUSP_CYC - 2, memmap_pkg::SUSP_CYC + 3);
            pulse_wait(1, memmap_pkg::RESTART_CYC - 2, memmap_pkg::RESTART_CYC + 3);
            @(negedge sys_clk);
            flash_done = 1'b1;
            @(negedge sys_clk);
            flash_done = 1'b0;
            repeat (2) @(negedge sys_clk);
            check("idle_after_done", 20'(i_mem_bus_if.busy), 20'h0);
        end
        $display("test flash suspend done");
        wrap_up();
    end
endmodule : test_memory_map_decoder
